// ===== verilog/flag_conditional_branch_unit.sv
// flag conditional branch unit: condition test and pc update
`timescale 1ns/1ps
`default_nettype none
module flag_conditional_branch_unit (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // branch request from decode
  input wire logic REQ_VALID,
  input wire branch_pkg::branch_req_t REQ,
  // status flags, read only
  input wire logic [7:0] SREG_IN,
  // program counter
  input wire logic [branch_pkg::PC_WIDTH-1:0] PC_IN,
  output logic [branch_pkg::PC_WIDTH-1:0] PC_OUT,
  output logic PC_LOAD,
  // status
  output logic BUSY,
  output logic DONE,
  output logic TAKEN
);
  import branch_pkg::*;

  // a request seen while busy is dropped, not queued: decode must
  // hold it back until the cycle after the taken branch ends
  // the target is registered on acceptance and holds until the next
  // taken branch, so the pc side may load it late

  // widths and bit positions the logic below relies on
  localparam int SREG_BITS = 8;
  localparam int EXT_BITS = PC_WIDTH - OFFSET_WIDTH;
  localparam logic PULSE_OFF = 1'b0;

  generate
    if (OFFSET_WIDTH < 2 || EXT_BITS < 1) begin : g_bad_offset
      $error("offset must be at least 2 bits and narrower than the pc");
    end
    if (FLAG_C >= SREG_BITS || FLAG_N >= SREG_BITS || FLAG_V >= SREG_BITS) begin : g_bad_flag
      $error("a flag position lies outside the status byte");
    end
    if (FLAG_C == FLAG_N || FLAG_C == FLAG_V || FLAG_N == FLAG_V) begin : g_same_flag
      $error("two flags share one status bit");
    end
  endgenerate

  // state and output registers
  branch_state_t state_reg;
  branch_state_t state_next;

  logic [PC_WIDTH-1:0] pc_reg;
  logic [PC_WIDTH-1:0] pc_next;

  logic load_reg;
  logic load_next;
  logic done_reg;
  logic done_next;
  logic taken_reg;
  logic taken_next;

  // status flags; the status byte is only read
  wire logic flag_c;
  wire logic flag_n;
  wire logic flag_v;
  wire logic signed_lt;
  assign flag_c = SREG_IN[FLAG_C];
  assign flag_n = SREG_IN[FLAG_N];
  assign flag_v = SREG_IN[FLAG_V];
  assign signed_lt = flag_n ^ flag_v;

  // which condition the request names
  wire logic sel_carry_set;
  wire logic sel_carry_clear;
  wire logic sel_unsigned_ge;
  wire logic sel_unsigned_lt;
  wire logic sel_negative;
  wire logic sel_positive;
  wire logic sel_signed_ge;
  wire logic sel_signed_lt;
  assign sel_carry_set = (REQ.cond == BRANCH_ON_CARRY_SET);
  assign sel_carry_clear = (REQ.cond == BRANCH_ON_CARRY_CLEAR);
  assign sel_unsigned_ge = (REQ.cond == BRANCH_UNSIGNED_GE);
  assign sel_unsigned_lt = (REQ.cond == BRANCH_UNSIGNED_LT);
  assign sel_negative = (REQ.cond == BRANCH_ON_NEGATIVE);
  assign sel_positive = (REQ.cond == BRANCH_ON_POSITIVE);
  assign sel_signed_ge = (REQ.cond == BRANCH_SIGNED_GE);
  assign sel_signed_lt = (REQ.cond == BRANCH_SIGNED_LT);

  // condition results; unknown codes select nothing and are not taken
  wire logic hit_carry_set;
  wire logic hit_carry_clear;
  wire logic hit_unsigned_ge;
  wire logic hit_unsigned_lt;
  wire logic hit_negative;
  wire logic hit_positive;
  wire logic hit_signed_ge;
  wire logic hit_signed_lt;
  assign hit_carry_set = sel_carry_set && flag_c;
  assign hit_carry_clear = sel_carry_clear && !flag_c;
  assign hit_unsigned_ge = sel_unsigned_ge && !flag_c;
  assign hit_unsigned_lt = sel_unsigned_lt && flag_c;
  assign hit_negative = sel_negative && flag_n;
  assign hit_positive = sel_positive && !flag_n;
  assign hit_signed_ge = sel_signed_ge && !signed_lt;
  assign hit_signed_lt = sel_signed_lt && signed_lt;

  wire logic cond_true;
  assign cond_true = hit_carry_set
    || hit_carry_clear
    || hit_unsigned_ge
    || hit_unsigned_lt
    || hit_negative
    || hit_positive
    || hit_signed_ge
    || hit_signed_lt;

  // sign extension, so backward branches reach lower addresses
  wire logic [PC_WIDTH-1:0] offset_ext;
  wire logic [PC_WIDTH-1:0] target;
  generate
    for (genvar b = 0; b < PC_WIDTH; b++) begin : g_sext
      if (b < OFFSET_WIDTH) begin : g_low
        assign offset_ext[b] = REQ.offset[b];
      end else begin : g_high
        assign offset_ext[b] = REQ.offset[OFFSET_WIDTH-1];
      end
    end
  endgenerate
  // wraps modulo the pc width
  assign target = PC_IN + offset_ext + PC_STEP;

  // request handshake
  wire logic idle;
  wire logic second;
  wire logic accept;
  wire logic accept_taken;
  wire logic accept_skip;
  assign idle = (state_reg == ST_IDLE);
  assign second = (state_reg == ST_SECOND);
  assign accept = REQ_VALID && idle;
  assign accept_taken = accept && cond_true;
  assign accept_skip = accept && !cond_true;

  // not taken ends after one cycle, taken spends a second cycle loading the pc
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept_taken) begin
          state_next = ST_SECOND;
        end
      end
      ST_SECOND: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign pc_next = accept_taken ? target : pc_reg;
  assign load_next = second;
  assign done_next = accept_skip || second;
  assign taken_next = second;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // pulses last one cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      load_reg <= PULSE_OFF;
    end else begin
      load_reg <= load_next;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      done_reg <= PULSE_OFF;
    end else begin
      done_reg <= done_next;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      taken_reg <= PULSE_OFF;
    end else begin
      taken_reg <= taken_next;
    end
  end

  // outputs straight from flops, BUSY decoded from state_reg; no flag is ever driven back
  assign PC_OUT = pc_reg;
  assign PC_LOAD = load_reg;
  assign DONE = done_reg;
  assign TAKEN = taken_reg;
  assign BUSY = second;
endmodule : flag_conditional_branch_unit
`default_nettype wire

// ===== verilog/branch_pkg.sv
// constants and types for the flag conditional branch unit
// How it works
// - taken branch loads pc plus offset plus one
// - carry set/clear branches test carry flag
// - unsigned ge on carry zero, lt on one
// - negative branch on n one, positive on zero
// - signed ge when n xor v is zero
// - branches never modify any status flag
// - signed lt when n xor v is one
`default_nettype none
package branch_pkg;
  localparam int PC_WIDTH = 16;
  localparam int OFFSET_WIDTH = 7;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_WIDTH-1:0] PC_STEP = 16'h0001;
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;

  typedef enum logic [3:0] {
    COND_NONE = 4'h0,
    BRANCH_ON_CARRY_SET = 4'h1,
    BRANCH_ON_CARRY_CLEAR = 4'h2,
    BRANCH_UNSIGNED_GE = 4'h3,
    BRANCH_UNSIGNED_LT = 4'h4,
    BRANCH_ON_NEGATIVE = 4'h5,
    BRANCH_ON_POSITIVE = 4'h6,
    BRANCH_SIGNED_GE = 4'h7,
    BRANCH_SIGNED_LT = 4'h8
  } branch_cond_t;

  typedef struct packed {
    branch_cond_t cond;
    logic [OFFSET_WIDTH-1:0] offset;
  } branch_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SECOND = 2'b10
  } branch_state_t;
endpackage : branch_pkg
`default_nettype wire

// ===== tb/branch_sva.sv
// assertions on the ports of the flag conditional branch unit
`timescale 1ns/1ps
`default_nettype none
module branch_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // request side
  input wire logic REQ_VALID,
  input wire branch_pkg::branch_req_t REQ,
  input wire logic [7:0] SREG_IN,
  input wire logic [branch_pkg::PC_WIDTH-1:0] PC_IN,
  // answer side
  input wire logic [branch_pkg::PC_WIDTH-1:0] PC_OUT,
  input wire logic PC_LOAD,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic TAKEN
);
  import branch_pkg::*;

  wire logic flag_c = SREG_IN[FLAG_C];
  wire logic flag_n = SREG_IN[FLAG_N];
  wire logic flag_x = SREG_IN[FLAG_N] ^ SREG_IN[FLAG_V];
  // expected outcome per condition code; unknown codes never taken
  wire logic [15:0] cond_map =
    {7'h00, flag_x, ~flag_x, ~flag_n, flag_n, flag_c, ~flag_c, ~flag_c, flag_c, 1'h0};
  wire logic hit = cond_map[REQ.cond];
  wire logic [PC_WIDTH-1:0] want_pc =
    PC_IN + {{(PC_WIDTH-OFFSET_WIDTH){REQ.offset[OFFSET_WIDTH-1]}}, REQ.offset} + PC_STEP;

  sequence s_accept;
    REQ_VALID && !BUSY;
  endsequence
  sequence s_second;
    BUSY && !DONE && !TAKEN;
  endsequence
  sequence s_finish;
    !BUSY && DONE && TAKEN && PC_LOAD;
  endsequence

  property p_cond;
    @(posedge CLOCK) disable iff (RST) s_accept |=> BUSY == $past(hit) && DONE != BUSY;
  endproperty
  a_cond: assert property (p_cond) else $error("bad outcome");
  property p_once;
    @(posedge CLOCK) disable iff (RST) BUSY |=> !BUSY && DONE;
  endproperty
  a_once: assert property (p_once) else $error("bad busy");
  property p_taken_walk;
    @(posedge CLOCK) disable iff (RST) s_accept ##0 hit |=> s_second ##1 s_finish;
  endproperty
  a_taken_walk: assert property (p_taken_walk) else $error("taken walk wrong");
  property p_target;
    @(posedge CLOCK) disable iff (RST) s_accept ##0 hit |=> PC_OUT == $past(want_pc);
  endproperty
  a_target: assert property (p_target) else $error("wrong target");
  property p_skip;
    @(posedge CLOCK) disable iff (RST)
      s_accept ##0 !hit |=> DONE && !TAKEN && !PC_LOAD && !BUSY;
  endproperty
  a_skip: assert property (p_skip) else $error("wrong skip");
  property p_pc_hold;
    @(posedge CLOCK) disable iff (RST) !(REQ_VALID && !BUSY) |=> $stable(PC_OUT);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
  property p_taken_late;
    @(posedge CLOCK) disable iff (RST) TAKEN |-> PC_LOAD && DONE && $past(BUSY);
  endproperty
  a_taken_late: assert property (p_taken_late) else $error("early taken");
endmodule : branch_sva

bind flag_conditional_branch_unit branch_sva i_sva (
  .CLOCK(CLOCK),
  .RST(RST),
  .REQ_VALID(REQ_VALID),
  .REQ(REQ),
  .SREG_IN(SREG_IN),
  .PC_IN(PC_IN),
  .PC_OUT(PC_OUT),
  .PC_LOAD(PC_LOAD),
  .BUSY(BUSY),
  .DONE(DONE),
  .TAKEN(TAKEN)
);
`default_nettype wire

// ===== tb/flag_conditional_branch_unit_test.sv
// testbench for the flag conditional branch unit
`timescale 1ns/1ps
`default_nettype none
module flag_conditional_branch_unit_test;
  import branch_pkg::*;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic PC_LOAD;
  logic BUSY;
  logic DONE;
  logic TAKEN;
  branch_req_t REQ = '0;
  logic [7:0] SREG_IN = 8'h00;
  logic [15:0] PC_IN = 16'h1234;
  logic [15:0] PC_OUT;
  // expected taken bit per condition code, for each of the two flag sets
  logic [15:0] tab [2] = '{16'h00B2, 16'h014C};
  int n_fail = 0;
  int n_checks = 0;
  always #2.5 CLOCK = ~CLOCK;
  flag_conditional_branch_unit i_dut (
    .CLOCK(CLOCK),
    .RST(RST),
    .REQ_VALID(REQ_VALID),
    .REQ(REQ),
    .SREG_IN(SREG_IN),
    .PC_IN(PC_IN),
    .PC_OUT(PC_OUT),
    .PC_LOAD(PC_LOAD),
    .BUSY(BUSY),
    .DONE(DONE),
    .TAKEN(TAKEN)
  );
  task automatic chk(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk
  task automatic br(input branch_cond_t k, input logic [6:0] o, input logic e);
    logic [15:0] want;
    want = PC_IN + {{9{o[6]}}, o} + PC_STEP;
    @(posedge CLOCK);
    #1;
    REQ = '{k, o};
    REQ_VALID = 1'b1;
    @(posedge CLOCK);
    #1;
    REQ_VALID = 1'b0;
    if (e) begin
      chk(BUSY && !DONE && PC_OUT === want, "no busy or bad target");
      @(posedge CLOCK);
      #1;
      chk(!BUSY && DONE && TAKEN && PC_LOAD && PC_OUT === want, "no finish");
    end else begin
      chk(DONE && !TAKEN && !PC_LOAD && !BUSY, "wrongly taken");
    end
  endtask : br
  task t_cond;
    for (int j = 0; j < 2; j++) begin
      SREG_IN = j ? 8'h1A : 8'h0D;
      for (int i = 0; i < 16; i++)
        br(branch_cond_t'(4'(i)), 7'(i * 9), tab[j][i]);
    end
    $display("t_cond done");
  endtask : t_cond
  // a request held through the busy cycle is dropped; then a reset in mid-run
  task t_refuse;
    @(posedge CLOCK);
    #1;
    SREG_IN = 8'h01;
    REQ = '{BRANCH_ON_CARRY_SET, 7'h05};
    REQ_VALID = 1'b1;
    @(posedge CLOCK);
    #1;
    REQ = '{BRANCH_ON_CARRY_SET, 7'h20};
    chk(BUSY && PC_OUT === 16'h123A, "first not taken");
    @(posedge CLOCK);
    #1;
    REQ_VALID = 1'b0;
    chk(DONE && TAKEN && PC_OUT === 16'h123A, "busy request not dropped");
    RST = 1'b1;
    #1;
    chk(!DONE && !TAKEN && !PC_LOAD && !BUSY && PC_OUT === 16'h0000, "no reset");
    @(posedge CLOCK);
    #1;
    RST = 1'b0;
    @(posedge CLOCK);
    #1;
    chk(!DONE && !TAKEN && !PC_LOAD && !BUSY && PC_OUT === 16'h0000, "pulse after reset");
    $display("t_refuse done");
  endtask : t_refuse
  task tally_and_finish;
    $display("%0d fails in %0d checks", n_fail, n_checks);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    #48.5;
    RST = 1'b0;
    t_cond;
    t_refuse;
    tally_and_finish;
  end
  // about 90 cycles of tests; the limit leaves ample margin
  initial begin
    #2000;
    n_fail++;
    tally_and_finish;
  end
endmodule : flag_conditional_branch_unit_test
`default_nettype wire
